// ===== rtl/omc_pkg.sv
// Constants, register map and types of the optical module control block.
package omc_pkg;
	localparam longint unsigned CLK_HZ = 64'd40000000;
	localparam longint unsigned US_HZ = 64'd1000000;
	localparam longint unsigned MS_HZ = 64'd1000;

	// Documented times, each in its own unit.
	localparam longint unsigned T_2W_MS = 64'd300;
	localparam longint unsigned T_START_MS = 64'd300;
	localparam longint unsigned T_START_COOLED_S = 64'd90;
	localparam longint unsigned T_PL2_UP_MS = 64'd300;
	localparam longint unsigned T_PL2_DN_MS = 64'd300;
	localparam longint unsigned T_FAULT_MS = 64'd1;
	localparam longint unsigned T_FAULT_COOLED_MS = 64'd50;
	localparam longint unsigned T_RESET_US = 64'd10;
	localparam longint unsigned T_RS_FC_US = 64'd500;
	localparam longint unsigned T_RS_MS = 64'd10;
	localparam longint unsigned T_LOS_ON_US = 64'd100;
	localparam longint unsigned T_LOS_OFF_US = 64'd100;

	// Longest times round down, the least time rounds up.
	localparam logic [31:0] MGMT_CYC = 32'((T_2W_MS * CLK_HZ) / MS_HZ);
	localparam logic [31:0] START_CYC = 32'((T_START_MS * CLK_HZ) / MS_HZ);
	localparam logic [31:0] START_COOLED_CYC = 32'(T_START_COOLED_S * CLK_HZ);
	localparam logic [31:0] PL2_UP_CYC = 32'((T_PL2_UP_MS * CLK_HZ) / MS_HZ);
	localparam logic [31:0] PL2_DN_CYC = 32'((T_PL2_DN_MS * CLK_HZ) / MS_HZ);
	localparam logic [31:0] FAULT_CYC = 32'((T_FAULT_MS * CLK_HZ) / MS_HZ);
	localparam logic [31:0] FAULT_COOLED_CYC =
		32'((T_FAULT_COOLED_MS * CLK_HZ) / MS_HZ);
	localparam logic [15:0] RESET_CYC =
		16'((T_RESET_US * CLK_HZ + US_HZ - 64'd1) / US_HZ);
	localparam logic [31:0] RS_FC_CYC = 32'((T_RS_FC_US * CLK_HZ) / US_HZ);
	localparam logic [31:0] RS_CYC = 32'((T_RS_MS * CLK_HZ) / MS_HZ);
	localparam logic [31:0] LOS_ON_CYC = 32'((T_LOS_ON_US * CLK_HZ) / US_HZ);
	localparam logic [31:0] LOS_OFF_CYC = 32'((T_LOS_OFF_US * CLK_HZ) / US_HZ);
	// Cycles spent in synchronisers and output flops ahead of any deadline.
	localparam logic [31:0] PIPE_CYC = 32'h0000_0004;

	// Register map, byte addresses.
	localparam int ADDR_W = 5;
	localparam logic [4:0] ADDR_CTRL = 5'h00;
	localparam logic [4:0] ADDR_STATUS = 5'h04;
	localparam logic [4:0] ADDR_IRQ_STATUS = 5'h08;
	localparam logic [4:0] ADDR_IRQ_MASK = 5'h0c;

	// Control fields.
	localparam int CTRL_PL2 = 0;
	localparam int CTRL_COOLED = 1;
	localparam int CTRL_RATE_FC = 2;
	localparam logic [2:0] CTRL_RST = 3'h0;

	// Status fields.
	localparam int STS_MGMT_RDY = 0;
	localparam int STS_OPER = 1;
	localparam int STS_FAULT = 2;
	localparam int STS_LOS = 3;
	localparam int STS_RATE_OK = 4;
	localparam int STS_PL2 = 5;
	localparam int STS_LASER = 6;

	// Interrupt status and mask fields.
	localparam int IRQ_FAULT = 0;
	localparam int IRQ_LOS = 1;
	localparam int IRQ_OPER = 2;
	localparam int IRQ_RATE = 3;
	localparam logic [3:0] IRQ_RST = 4'h0;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		ST_DOWN  = 4'b0001,
		ST_BOOT  = 4'b0010,
		ST_RUN   = 4'b0100,
		ST_FAULT = 4'b1000
	} omc_state_t;
endpackage

// ===== rtl/omc_qual.sv
// Qualifier that follows a synchronised level once it has held a set time.
`timescale 1ns/1ps
`default_nettype none
module omc_qual (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        sample,
	input  wire logic [31:0] limit,
	output logic             level_q
);
	typedef struct packed {
		logic        lvl;
		logic [31:0] cnt;
	} omc_qual_st_t;

	omc_qual_st_t q;
	omc_qual_st_t d;

	// A level that flips back before the limit restarts the count.
	always_comb begin
		d = q;
		if (sample == q.lvl) begin
			d.cnt = 32'h0000_0000;
		end else if (q.cnt >= limit) begin
			d.lvl = sample;
			d.cnt = 32'h0000_0000;
		end else begin
			d.cnt = q.cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign level_q = q.lvl;
endmodule
`default_nettype wire

// ===== rtl/omc_top.sv
// Control and status pin logic of a pluggable optical module.
`timescale 1ns/1ps
`default_nettype none
module omc_top #(
	parameter logic [31:0] P_MGMT_CYC         = omc_pkg::MGMT_CYC,
	parameter logic [31:0] P_START_CYC        = omc_pkg::START_CYC,
	parameter logic [31:0] P_START_COOLED_CYC = omc_pkg::START_COOLED_CYC,
	parameter logic [31:0] P_PL2_UP_CYC       = omc_pkg::PL2_UP_CYC,
	parameter logic [31:0] P_PL2_DN_CYC       = omc_pkg::PL2_DN_CYC,
	parameter logic [31:0] P_FAULT_CYC        = omc_pkg::FAULT_CYC,
	parameter logic [31:0] P_FAULT_COOLED_CYC = omc_pkg::FAULT_COOLED_CYC,
	parameter logic [31:0] P_RS_FC_CYC        = omc_pkg::RS_FC_CYC,
	parameter logic [31:0] P_RS_CYC           = omc_pkg::RS_CYC
) (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic [omc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [omc_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic                       laser_off_req,
	input  wire logic                       rate_select_low,
	input  wire logic                       rate_select_high,
	input  wire logic                       supply_good,
	input  wire logic                       fault_detect,
	input  wire logic                       signal_detect,
	output logic                            laser_enable,
	output logic                            laser_fault_oe,
	output logic                            loss_of_light_oe,
	output logic                            rate_stable,
	output logic                            mgmt_ready,
	output logic                            module_ready,
	output logic                            power_level2,
	output logic                            irq
);
	import omc_pkg::*;

	typedef struct packed {
		logic [1:0]        off_sy;
		logic [1:0]        rsl_sy;
		logic [1:0]        rsh_sy;
		logic [1:0]        sup_sy;
		logic [1:0]        flt_sy;
		logic [1:0]        sig_sy;
		logic              off_prev;
		logic              rsl_prev;
		logic              rsh_prev;
		omc_state_t        st;
		logic [31:0]       start_cnt;
		logic [31:0]       mgmt_cnt;
		logic [31:0]       pwr_cnt;
		logic [31:0]       rate_cnt;
		logic [15:0]       rst_cnt;
		logic              rst_ok;
		logic              laser_en;
		logic              fault;
		logic              los;
		logic              rate_ok;
		logic              mgmt_rdy;
		logic              oper;
		logic              pl2;
		logic [2:0]        ctrl;
		logic [3:0]        ists;
		logic [3:0]        imask;
		logic              irq;
		logic              awready;
		logic              wready;
		logic              aw_hold;
		logic              w_hold;
		logic [ADDR_W-1:0] awa;
		logic [31:0]       wd;
		logic [3:0]        ws;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} omc_st_t;

	omc_st_t     q;
	omc_st_t     d;
	logic        flt_qual;
	logic        sig_qual;
	logic [31:0] flt_limit;
	logic [31:0] sig_limit;

	// Light returning and light leaving have one deadline each way.
	assign sig_limit = q.los ? (LOS_OFF_CYC - PIPE_CYC)
		: (LOS_ON_CYC - PIPE_CYC);
	assign flt_limit = q.ctrl[CTRL_COOLED]
		? (P_FAULT_COOLED_CYC - PIPE_CYC)
		: (P_FAULT_CYC - PIPE_CYC);

	omc_qual u_fault_qual (
		.aclk    (aclk),
		.aresetn (aresetn),
		.sample  (q.flt_sy[1]),
		.limit   (flt_limit),
		.level_q (flt_qual)
	);

	omc_qual u_sig_qual (
		.aclk    (aclk),
		.aresetn (aresetn),
		.sample  (q.sig_sy[1]),
		.limit   (sig_limit),
		.level_q (sig_qual)
	);

	always_comb begin
		logic        off;
		logic        off_fall;
		logic        rs_chg;
		logic        wr_go;
		logic [3:0]  clr;
		logic [3:0]  ev;
		logic [31:0] start_lim;
		logic [2:0]  nctrl;
		off = 1'b0;
		off_fall = 1'b0;
		rs_chg = 1'b0;
		wr_go = 1'b0;
		clr = 4'h0;
		ev = 4'h0;
		start_lim = 32'h0000_0000;
		nctrl = 3'h0;
		d = q;

		d.off_sy = {q.off_sy[0], laser_off_req};
		d.rsl_sy = {q.rsl_sy[0], rate_select_low};
		d.rsh_sy = {q.rsh_sy[0], rate_select_high};
		d.sup_sy = {q.sup_sy[0], supply_good};
		d.flt_sy = {q.flt_sy[0], fault_detect};
		d.sig_sy = {q.sig_sy[0], signal_detect};

		off = q.off_sy[1];
		off_fall = q.off_prev && !off;
		d.off_prev = off;
		start_lim = q.ctrl[CTRL_COOLED] ? (P_START_COOLED_CYC - PIPE_CYC)
			: (P_START_CYC - PIPE_CYC);

		// Register writes: address and data may arrive in either order.
		if (s_axi_awvalid && q.awready) begin
			d.aw_hold = 1'b1;
			d.awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && q.wready) begin
			d.w_hold = 1'b1;
			d.wd = s_axi_wdata;
			d.ws = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		wr_go = q.aw_hold && q.w_hold && !q.bvalid;
		if (wr_go) begin
			d.aw_hold = 1'b0;
			d.w_hold = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = RESP_OKAY;
			unique case (q.awa)
				ADDR_CTRL: begin
					if (q.ws[0]) begin
						nctrl = q.wd[2:0];
						d.ctrl = nctrl;
						// Stands in for the stop bit of a power-level write.
						if (nctrl[CTRL_PL2] != q.ctrl[CTRL_PL2]) begin
							d.pwr_cnt = nctrl[CTRL_PL2]
								? (P_PL2_UP_CYC - PIPE_CYC)
								: (P_PL2_DN_CYC - PIPE_CYC);
						end
					end
				end
				ADDR_STATUS: begin
				end
				ADDR_IRQ_STATUS: begin
					if (q.ws[0]) begin
						clr = q.wd[3:0];
					end
				end
				ADDR_IRQ_MASK: begin
					if (q.ws[0]) begin
						d.imask = q.wd[3:0];
					end
				end
				default: begin
					d.bresp = RESP_SLVERR;
				end
			endcase
		end

		// Register reads answer one cycle after the address is taken.
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && q.arready) begin
			d.rvalid = 1'b1;
			d.rresp = RESP_OKAY;
			d.rdata = 32'h0000_0000;
			unique case (s_axi_araddr)
				ADDR_CTRL: begin
					d.rdata[2:0] = q.ctrl;
				end
				ADDR_STATUS: begin
					d.rdata[STS_MGMT_RDY] = q.mgmt_rdy;
					d.rdata[STS_OPER] = q.oper;
					d.rdata[STS_FAULT] = q.fault;
					d.rdata[STS_LOS] = q.los;
					d.rdata[STS_RATE_OK] = q.rate_ok;
					d.rdata[STS_PL2] = q.pl2;
					d.rdata[STS_LASER] = q.laser_en;
				end
				ADDR_IRQ_STATUS: begin
					d.rdata[3:0] = q.ists;
				end
				ADDR_IRQ_MASK: begin
					d.rdata[3:0] = q.imask;
				end
				default: begin
					d.rresp = RESP_SLVERR;
				end
			endcase
		end

		// Power level change completes when its countdown runs out.
		if (q.pwr_cnt != 32'h0000_0000) begin
			d.pwr_cnt = q.pwr_cnt - 32'h0000_0001;
			if (q.pwr_cnt == 32'h0000_0001) begin
				d.pl2 = q.ctrl[CTRL_PL2];
			end
		end

		// Any rate select edge restarts the settling countdown.
		rs_chg = (q.rsl_sy[1] != q.rsl_prev) || (q.rsh_sy[1] != q.rsh_prev);
		d.rsl_prev = q.rsl_sy[1];
		d.rsh_prev = q.rsh_sy[1];
		if (rs_chg) begin
			d.rate_ok = 1'b0;
			d.rate_cnt = q.ctrl[CTRL_RATE_FC] ? (P_RS_FC_CYC - PIPE_CYC)
				: (P_RS_CYC - PIPE_CYC);
		end else if (q.rate_cnt != 32'h0000_0000) begin
			d.rate_cnt = q.rate_cnt - 32'h0000_0001;
			if (q.rate_cnt == 32'h0000_0001) begin
				d.rate_ok = 1'b1;
			end
		end

		d.los = !sig_qual;

		// Management side comes up on its own, independent of cooling.
		if (q.st != ST_DOWN && !q.mgmt_rdy) begin
			if (q.mgmt_cnt >= P_MGMT_CYC - PIPE_CYC) begin
				d.mgmt_rdy = 1'b1;
			end else begin
				d.mgmt_cnt = q.mgmt_cnt + 32'h0000_0001;
			end
		end

		// The reset pulse is timed while the off request stays high.
		if (!off) begin
			d.rst_cnt = 16'h0000;
		end else if (q.rst_cnt >= RESET_CYC - 16'h0001) begin
			d.rst_ok = 1'b1;
		end else begin
			d.rst_cnt = q.rst_cnt + 16'h0001;
		end

		unique case (q.st)
			ST_DOWN: begin
				if (q.sup_sy[1]) begin
					d.st = ST_BOOT;
					d.start_cnt = 32'h0000_0000;
					d.mgmt_cnt = 32'h0000_0000;
				end
			end
			ST_BOOT: begin
				if (flt_qual) begin
					d.st = ST_FAULT;
					d.fault = 1'b1;
				end else if (off_fall) begin
					d.start_cnt = 32'h0000_0000;
				end else if (q.start_cnt >= start_lim) begin
					d.st = ST_RUN;
				end else begin
					d.start_cnt = q.start_cnt + 32'h0000_0001;
				end
			end
			ST_RUN: begin
				if (flt_qual) begin
					d.st = ST_FAULT;
					d.fault = 1'b1;
				end
			end
			ST_FAULT: begin
				if (off_fall) begin
					d.rst_ok = 1'b0;
					if (q.rst_ok && !flt_qual) begin
						d.st = ST_BOOT;
						d.fault = 1'b0;
						d.start_cnt = 32'h0000_0000;
					end
				end
			end
		endcase
		if (!q.sup_sy[1]) begin
			d.st = ST_DOWN;
			d.fault = 1'b0;
			d.mgmt_rdy = 1'b0;
			d.rst_ok = 1'b0;
		end
		if (off_fall && q.st != ST_FAULT) begin
			d.rst_ok = 1'b0;
		end

		// Transmitter follows the off request directly in the boot and run states only.
		d.laser_en = !off && (d.st == ST_BOOT || d.st == ST_RUN);
		d.oper = (d.st == ST_RUN)
			&& !(q.ctrl[CTRL_PL2] && d.pwr_cnt != 32'h0000_0000);

		ev[IRQ_FAULT] = d.fault && !q.fault;
		ev[IRQ_LOS] = d.los != q.los;
		ev[IRQ_OPER] = d.oper && !q.oper;
		ev[IRQ_RATE] = d.rate_ok && !q.rate_ok;
		// A new event beats a clear in the same cycle.
		d.ists = (q.ists & ~clr) | ev;
		d.irq = |(d.ists & d.imask);

		d.awready = !d.aw_hold;
		d.wready = !d.w_hold;
		d.arready = !d.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.st <= ST_DOWN;
			q.ctrl <= CTRL_RST;
			q.imask <= IRQ_RST;
			q.rate_ok <= 1'b1;
			q.los <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Open-drain status pins pull low while their condition is absent.
	assign laser_enable = q.laser_en;
	assign laser_fault_oe = !q.fault;
	assign loss_of_light_oe = !q.los;
	assign rate_stable = q.rate_ok;
	assign mgmt_ready = q.mgmt_rdy;
	assign module_ready = q.oper;
	assign power_level2 = q.pl2;
	assign irq = q.irq;
	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bresp = q.bresp;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_arready = q.arready;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign s_axi_rvalid = q.rvalid;
endmodule
`default_nettype wire

// ===== sim/omc_host.sv
// Behavioural host board controller that drives and reads the control pins.
`timescale 1ns/1ps
`default_nettype none
module omc_host (
	input  wire logic aclk,
	input  wire logic laser_fault_oe,
	input  wire logic loss_of_light_oe,
	output logic      laser_off_req,
	output logic      rate_select_low,
	output logic      rate_select_high,
	output logic      fault_pin,
	output logic      los_pin
);
	// An unconnected off request reads high through its pull-up.
	initial begin
		laser_off_req = 1'b1;
		rate_select_low = 1'b0;
		rate_select_high = 1'b0;
	end
	// Released open-drain lines float up to the host pull-ups.
	assign fault_pin = !laser_fault_oe;
	assign los_pin = !loss_of_light_oe;

	task automatic set_off(input logic v);
		@(posedge aclk);
		laser_off_req <= v;
	endtask

	task automatic pulse_off(input int n);
		set_off(1'b1);
		repeat (n) @(posedge aclk);
		laser_off_req <= 1'b0;
	endtask

	task automatic flip(input logic hi);
		@(posedge aclk);
		if (hi)
			rate_select_high <= !rate_select_high;
		else
			rate_select_low <= !rate_select_low;
	endtask
endmodule
`default_nettype wire

// ===== sim/omc_assertions.sv
// Concurrent checks on the pins of the optical module control block.
`timescale 1ns/1ps
`default_nettype none
module omc_chk
	import omc_pkg::*;
#(
	parameter logic [31:0] P_MGMT_CYC         = 32'd200,
	parameter logic [31:0] P_FAULT_COOLED_CYC = 32'd150,
	parameter logic [31:0] P_RS_CYC           = 32'd120
) (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        laser_off_req,
	input wire logic        rate_select_low,
	input wire logic        rate_select_high,
	input wire logic        supply_good,
	input wire logic        fault_detect,
	input wire logic        signal_detect,
	input wire logic        laser_enable,
	input wire logic        laser_fault_oe,
	input wire logic        loss_of_light_oe,
	input wire logic        rate_stable,
	input wire logic        mgmt_ready,
	input wire logic        module_ready
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [15:0] sg_n, ft_n, sd_n, rs_n, lo_n;
	logic        sd_l;
	logic [1:0]  rs_l;

	function automatic logic [15:0] inc(input logic [15:0] c);
		return (c == 16'hffff) ? c : c + 16'h0001;
	endfunction

	// Run lengths of steady input conditions, saturating.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sg_n <= 16'h0000;
			ft_n <= 16'h0000;
			sd_n <= 16'h0000;
			rs_n <= 16'h0000;
			lo_n <= 16'h0000;
		end else begin
			sg_n <= supply_good ? inc(sg_n) : 16'h0000;
			ft_n <= (fault_detect && sg_n > 16'h0004 && !laser_off_req) ?
				inc(ft_n) : 16'h0000;
			sd_n <= (signal_detect != sd_l) ? 16'h0000 : inc(sd_n);
			rs_n <= ({rate_select_high, rate_select_low} != rs_l) ?
				16'h0000 : inc(rs_n);
			lo_n <= laser_off_req ? 16'h0000 : inc(lo_n);
		end
		sd_l <= signal_detect;
		rs_l <= {rate_select_high, rate_select_low};
	end

	chk_tx_off_req: assert property (laser_off_req [*4] |=> !laser_enable)
		else $error("laser stayed on under off request");
	chk_tx_on_req: assert property ((!laser_off_req) [*5] ##0 module_ready
		|-> laser_enable)
		else $error("laser off while operational and enabled");
	chk_fault_report: assert property (ft_n > P_FAULT_COOLED_CYC
		|-> !laser_fault_oe && !laser_enable)
		else $error("fault not reported in time");
	chk_fault_sticky: assert property (!laser_fault_oe && sg_n > 16'h0004
		&& lo_n > 16'h0004 |=> !laser_fault_oe)
		else $error("fault dropped without reset pulse");
	chk_los_follow: assert property (sd_n > LOS_ON_CYC
		|-> loss_of_light_oe == sd_l)
		else $error("loss of light does not follow input");
	chk_rate_settle: assert property (rs_n > P_RS_CYC |-> rate_stable)
		else $error("rate output not settled in time");
	chk_rate_drop: assert property ($changed(rate_select_low) ||
		$changed(rate_select_high) |-> ##[1:5] !rate_stable)
		else $error("rate change not flagged");
	chk_mgmt_ready: assert property (sg_n > P_MGMT_CYC |-> mgmt_ready)
		else $error("management not ready in time");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
endmodule
bind omc_top omc_chk #(.P_MGMT_CYC(P_MGMT_CYC),
	.P_FAULT_COOLED_CYC(P_FAULT_COOLED_CYC), .P_RS_CYC(P_RS_CYC)) u_chk (.*);
`default_nettype wire

// ===== sim/tb_omc_top.sv
// Self-checking bench for the optical module control block.
`timescale 1ns/1ps
`default_nettype none
module tb_omc_top;
	import omc_pkg::*;
	localparam int MG = 200, ST = 300, SC = 600, PL = 100;
	localparam int FT = 50, FC = 150, RF = 60, RS = 120;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [4:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = '0, wst = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic supply_good = 0, fault_detect = 0, signal_detect = 0;
	logic laser_off_req, rate_select_low, rate_select_high, fault_pin, los_pin;
	logic laser_enable, laser_fault_oe, loss_of_light_oe, rate_stable;
	logic mgmt_ready, module_ready, power_level2, irq;
	int err_count = 0, comparisons = 0, n_w;

	always #12.5 aclk = !aclk;

	omc_top #(.P_MGMT_CYC(MG), .P_START_CYC(ST), .P_START_COOLED_CYC(SC),
		.P_PL2_UP_CYC(PL), .P_PL2_DN_CYC(PL), .P_FAULT_CYC(FT),
		.P_FAULT_COOLED_CYC(FC), .P_RS_FC_CYC(RF), .P_RS_CYC(RS)) DUT (.*);

	omc_host u_host (.aclk(aclk), .laser_fault_oe(laser_fault_oe),
		.loss_of_light_oe(loss_of_light_oe), .laser_off_req(laser_off_req),
		.rate_select_low(rate_select_low), .rate_select_high(rate_select_high),
		.fault_pin(fault_pin), .los_pin(los_pin));

	task automatic stop_test();
		if (err_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	function automatic logic sig(input int s);
		case (s)
			0: return laser_enable;
			1: return fault_pin;
			2: return los_pin;
			3: return rate_stable;
			4: return mgmt_ready;
			5: return module_ready;
			6: return power_level2;
			default: return irq;
		endcase
	endfunction

	// Waits at most lim cycles for an output level, then checks it.
	task automatic wt(input int s, input logic v, input int lim, input string nm);
		n_w = 0;
		while (sig(s) !== v && n_w < lim) begin
			@(posedge aclk);
			#1;
			n_w++;
		end
		check(nm, sig(s), v);
		if (sig(s) !== v)
			stop_test();
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, wst};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		n = 0;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			n++;
		end while (s_axi_bvalid !== 1'b1 && n < 50);
		s_axi_bready <= 1'b0;
		check("bresp", s_axi_bresp, a > 5'h0f ? RESP_SLVERR : RESP_OKAY);
		if (n >= 50)
			stop_test();
	endtask

	task automatic rc(input logic [4:0] a, input logic [31:0] m, e,
		input string nm);
		int n;
		@(posedge aclk);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
		n = 0;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			n++;
		end while (s_axi_rvalid !== 1'b1 && n < 50);
		s_axi_rready <= 1'b0;
		check(nm, s_axi_rdata & m, e);
		check("rresp", s_axi_rresp, a > 5'h0f ? RESP_SLVERR : RESP_OKAY);
		if (n >= 50)
			stop_test();
	endtask

	initial begin
		u_host.set_off(1'b0);
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rc(ADDR_CTRL, 32'hffffffff, 32'h0, "ctrl_rst");
		rc(ADDR_IRQ_MASK, 32'hffffffff, 32'h0, "mask_rst");
		wst = 4'he;
		wr(ADDR_IRQ_MASK, 32'hf);
		wst = 4'hf;
		rc(ADDR_IRQ_MASK, 32'hffffffff, 32'h0, "mask_strobe");
		rc(5'h10, 32'hffffffff, 32'h0, "unmapped");
		wr(5'h14, 32'h1);
		@(posedge aclk) supply_good <= 1'b1;
		wt(4, 1'b1, MG, "mgmt_ready");
		wt(5, 1'b1, ST - n_w, "start_up");
		check("tx_on", laser_enable, 1'b1);
		rc(ADDR_STATUS, 32'h7f, 32'h5b, "status");
		u_host.set_off(1'b1);
		wt(0, 1'b0, 4000, "t_off");
		u_host.set_off(1'b0);
		wt(0, 1'b1, 80000, "t_on");
		wr(ADDR_CTRL, 32'h1);
		wt(6, 1'b1, PL, "pl2_up");
		wt(5, 1'b1, PL - n_w, "pl2_oper");
		wr(ADDR_CTRL, 32'h0);
		wt(6, 1'b0, PL, "pl2_down");
		wr(ADDR_IRQ_STATUS, 32'hf);
		wr(ADDR_IRQ_MASK, 32'h1 << IRQ_RATE);
		wr(ADDR_CTRL, 32'h1 << CTRL_RATE_FC);
		u_host.flip(1'b0);
		wt(3, 1'b0, 8, "rs_drop");
		wt(3, 1'b1, RF, "rs_fc");
		wt(7, 1'b1, 4, "irq_set");
		wr(ADDR_IRQ_STATUS, 32'h1 << IRQ_RATE);
		wt(7, 1'b0, 4, "irq_clear");
		wr(ADDR_IRQ_MASK, 32'h0);
		wr(ADDR_CTRL, 32'h0);
		u_host.flip(1'b1);
		wt(3, 1'b0, 8, "rs_drop2");
		wt(3, 1'b1, RS, "rs_slow");
		rc(ADDR_IRQ_STATUS, 32'h8, 32'h8, "irq_sticky");
		check("irq_masked", irq, 1'b0);
		@(posedge aclk) signal_detect <= 1'b1;
		wt(2, 1'b0, int'(LOS_OFF_CYC), "los_off");
		@(posedge aclk) signal_detect <= 1'b0;
		wt(2, 1'b1, int'(LOS_ON_CYC), "los_on");
		@(posedge aclk) fault_detect <= 1'b1;
		wt(1, 1'b1, FT, "fault_on");
		check("fault_tx", laser_enable, 1'b0);
		u_host.pulse_off(100);
		repeat (8) @(posedge aclk);
		check("short_pulse", fault_pin, 1'b1);
		@(posedge aclk) fault_detect <= 1'b0;
		repeat (8) @(posedge aclk);
		check("fault_hold", fault_pin, 1'b1);
		u_host.pulse_off(400);
		wt(1, 1'b0, 8, "fault_clear");
		wt(5, 1'b1, ST, "recover");
		wr(ADDR_CTRL, 32'h1 << CTRL_COOLED);
		@(posedge aclk) fault_detect <= 1'b1;
		wt(1, 1'b1, FC, "fault_cooled");
		@(posedge aclk) fault_detect <= 1'b0;
		u_host.pulse_off(400);
		wt(1, 1'b0, 8, "fault_clear2");
		wt(5, 1'b1, SC, "recover_cooled");
		@(posedge aclk) supply_good <= 1'b0;
		wt(4, 1'b0, 8, "mgmt_drop");
		check("tx_down", laser_enable, 1'b0);
		@(posedge aclk) supply_good <= 1'b1;
		@(posedge aclk) aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rc(ADDR_CTRL, 32'hffffffff, 32'h0, "ctrl_rst2");
		stop_test();
	end
endmodule
`default_nettype wire
